// >>> rtl/scbc_pkg.sv
// shared constants and types for the sdram command and bank control block
package scbc_pkg;
    localparam int BANKS = 4;
    localparam int BANK_W = 2;
    localparam int ROW_W = 13;
    localparam int COL_W = 9;
    localparam int DQ_W = 16;
    localparam int MASK_W = 2;
    localparam int SCOPE_BIT = 10;
    localparam int MASK_LAT = 2;
    localparam logic [COL_W-1:0] COL_LAST = 9'h1ff;
    localparam logic [COL_W-1:0] COL_ZERO = 9'h000;
    localparam logic [9:0] FULL_PAGE_LEN = 10'h3ff;
    typedef enum logic [3:0] {
        SCBC_NOP, SCBC_DESELECT, SCBC_ROW_OPEN, SCBC_CLOSE_ONE, SCBC_CLOSE_ALL,
        SCBC_READ, SCBC_READ_AP, SCBC_WRITE, SCBC_WRITE_AP, SCBC_MODE_SET,
        SCBC_BURST_STOP, SCBC_AUTO_REFRESH, SCBC_SELF_REFRESH, SCBC_INHIBIT
    } scbc_cmd_t;
    typedef enum logic [1:0] {SCBC_RUN, SCBC_SUSPEND, SCBC_POWER_DOWN, SCBC_SELF_REF} scbc_pwr_t;
endpackage : scbc_pkg

// >>> rtl/scbc_decode.sv
// command decoder: chip select, strobes and clock-enable history to a command code
`timescale 1ns/10ps
module scbc_decode (
    // clock-enable history
    input wire logic cke_prev,
    input wire logic cke_now,
    // strobes, active low, and the active-high scope bit
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic scope_bit,
    // result
    output scbc_pkg::scbc_cmd_t cmd
);
    always_comb begin
        cmd = scbc_pkg::SCBC_INHIBIT;
        if (!cke_prev) begin
            cmd = scbc_pkg::SCBC_INHIBIT; // [R2]
        end else if (cs_n) begin
            cmd = scbc_pkg::SCBC_DESELECT; // [R24]
        end else begin
            case ({ras_n, cas_n, we_n})
                3'h7: cmd = scbc_pkg::SCBC_NOP; // [R25]
                3'h6: cmd = scbc_pkg::SCBC_BURST_STOP; // [R25]
                3'h3: cmd = scbc_pkg::SCBC_ROW_OPEN; // [R4]
                3'h2: cmd = scope_bit ? scbc_pkg::SCBC_CLOSE_ALL
                                      : scbc_pkg::SCBC_CLOSE_ONE; // [R9] [R10]
                3'h5: cmd = scope_bit ? scbc_pkg::SCBC_READ_AP : scbc_pkg::SCBC_READ; // [R13]
                3'h4: cmd = scope_bit ? scbc_pkg::SCBC_WRITE_AP : scbc_pkg::SCBC_WRITE;
                3'h1: cmd = cke_now ? scbc_pkg::SCBC_AUTO_REFRESH
                                    : scbc_pkg::SCBC_SELF_REFRESH; // [R25]
                3'h0: cmd = scbc_pkg::SCBC_MODE_SET;
                default: cmd = scbc_pkg::SCBC_INHIBIT;
            endcase
        end
    end
endmodule : scbc_decode

// >>> rtl/scbc_row_store.sv
// per-bank open-row store, read data registered
`timescale 1ns/10ps
module scbc_row_store #(
    parameter int DEPTH = scbc_pkg::BANKS,
    parameter int WIDTH = scbc_pkg::ROW_W
) (
    // clock
    input wire logic clock,
    // write side
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input wire logic [WIDTH-1:0] wr_data,
    // read side
    input wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    initial begin
        if (DEPTH < 2) $error("row store depth too small");
    end
    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end
    always_ff @(posedge clock) begin
        rd_data <= mem[rd_idx];
    end
endmodule : scbc_row_store

// >>> rtl/scbc_ctrl.sv
// sdram command decode, bank state and read burst sequencing
`timescale 1ns/10ps
// Summary of operation
// R1: all command, address, mask inputs sampled only on the rising clock edge.
// R2: decode uses clock enable now and one clock earlier; earlier must be high.
// R3: four banks, each idle or active, picked by bank_select.
// R4: row_open_command opens an idle bank and latches the row address.
// R5: controller waits row_to_column_delay before column access.
// R6: controller closes a bank before opening another row in it.
// R7: controller spaces opens to one bank by row_cycle_time.
// R8: controller spaces opens across banks by bank_to_bank_open_delay.
// R9: precharge with scope bit low closes only the selected bank.
// R10: precharge with scope bit high closes all banks, idle ones too.
// R11: controller waits minimum active time before closing a bank.
// R12: controller closes every bank before maximum active time.
// R13: read command decoded; column on low address bits; scope bit selects auto-precharge.
// R14: first word after cas latency, then one word every clock.
// R15: data outputs released when a burst ends uncontinued.
// R16: full-page burst runs until stopped, wrapping to column zero.
// R17: output mask suppresses the word two clocks later.
// R18: a new read replaces the running burst on any clock.
// R19: precharge to the bank stops its read burst and closes it.
// R20: controller raises masks two clocks before an interrupting write.
// R21: controller leaves one released clock before the write.
// R22: controller raises masks one clock early against internal contention.
// R23: power-down request during a burst becomes clock suspend.
// R24: chip select high ignores the command.
// R25: nop, burst stop, auto refresh and self refresh entry decoded.
// R26: a low byte mask enables output, high disables it, per lane.
module scbc_ctrl #(
    parameter int CAS_LAT = 2,
    parameter int COL_BITS = scbc_pkg::COL_W
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // command pins, active low strobes
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [scbc_pkg::BANK_W-1:0] bank_select,
    input wire logic [scbc_pkg::ROW_W-1:0] addr,
    input wire logic [scbc_pkg::MASK_W-1:0] byte_mask,
    // mode configuration: burst length in words, full page overrides
    input wire logic [3:0] burst_len,
    input wire logic full_page,
    // array read data for the addressed column
    input wire logic [scbc_pkg::DQ_W-1:0] array_data,
    // array read address
    output logic [scbc_pkg::BANK_W-1:0] array_bank_r,
    output logic [scbc_pkg::ROW_W-1:0] array_row_r,
    output logic [COL_BITS-1:0] array_col_r,
    // data pins
    output logic [scbc_pkg::DQ_W-1:0] dq_out_r,
    output logic [scbc_pkg::DQ_W-1:0] dq_oe_r,
    // status
    output logic [scbc_pkg::BANKS-1:0] bank_active_r,
    output scbc_pkg::scbc_pwr_t power_state_r,
    output logic refresh_pulse_r,
    output logic burst_busy_r
);
    localparam int LANE_W = scbc_pkg::DQ_W / scbc_pkg::MASK_W;
    initial begin
        if (CAS_LAT < 2 || CAS_LAT > 3) $error("cas latency must be 2 or 3");
        if (COL_BITS != scbc_pkg::COL_W) $error("column width unsupported");
        if (scbc_pkg::MASK_LAT != 2) $error("mask pipeline is built for two stages");
    end

    function automatic logic is_close(input scbc_pkg::scbc_cmd_t c);
        return c == scbc_pkg::SCBC_CLOSE_ONE || c == scbc_pkg::SCBC_CLOSE_ALL;
    endfunction
    function automatic logic is_read(input scbc_pkg::scbc_cmd_t c);
        return c == scbc_pkg::SCBC_READ || c == scbc_pkg::SCBC_READ_AP;
    endfunction

    logic cke_prev_r;
    scbc_pkg::scbc_cmd_t cmd;
    logic [scbc_pkg::ROW_W-1:0] open_row;
    logic [COL_BITS-1:0] col_r;
    logic [COL_BITS-1:0] col_nxt;
    logic [9:0] left_r;
    logic [scbc_pkg::BANK_W-1:0] burst_bank_r;
    logic burst_ap_r;
    logic [CAS_LAT-1:0] valid_pipe_r;
    logic [scbc_pkg::MASK_W-1:0] mask_d1_r;
    logic [scbc_pkg::MASK_W-1:0] mask_d2_r;
    logic stop_hit;
    logic [scbc_pkg::DQ_W-1:0] word_pipe_r [CAS_LAT-1];

    always_ff @(posedge clock) begin
        if (srst) cke_prev_r <= 1'b1;
        else cke_prev_r <= cke; // [R2]
    end

    scbc_decode u_decode (
        .cke_prev(cke_prev_r),
        .cke_now(cke),
        .cs_n(cs_n),
        .ras_n(ras_n),
        .cas_n(cas_n),
        .we_n(we_n),
        .scope_bit(addr[scbc_pkg::SCOPE_BIT]),
        .cmd(cmd)
    );

    // rows read back one cycle later, in step with the cas pipeline
    scbc_row_store #(.DEPTH(scbc_pkg::BANKS), .WIDTH(scbc_pkg::ROW_W)) u_rows (
        .clock(clock),
        .wr_en(cmd == scbc_pkg::SCBC_ROW_OPEN && !bank_active_r[bank_select]), // [R4]
        .wr_idx(bank_select),
        .wr_data(addr),
        .rd_idx(is_read(cmd) ? bank_select : burst_bank_r),
        .rd_data(open_row)
    );

    // bank state
    always_ff @(posedge clock) begin
        if (srst) begin
            bank_active_r <= '0;
        end else if (cmd == scbc_pkg::SCBC_CLOSE_ALL) begin
            bank_active_r <= '0; // [R10]
        end else if (cmd == scbc_pkg::SCBC_CLOSE_ONE) begin
            bank_active_r[bank_select] <= 1'b0; // [R9] [R3]
        end else if (cmd == scbc_pkg::SCBC_ROW_OPEN) begin
            bank_active_r[bank_select] <= 1'b1; // [R4] [R3]
        end else if (stop_hit && burst_ap_r && !full_page) begin
            bank_active_r[burst_bank_r] <= 1'b0;
        end
    end

    // natural end of a counted burst; held off while suspended so auto-precharge waits too
    always_comb begin
        stop_hit = burst_busy_r && left_r == 10'h001;
        if (!full_page && burst_len == 4'h0) stop_hit = burst_busy_r;
        if (power_state_r == scbc_pkg::SCBC_SUSPEND) stop_hit = 1'b0;
    end

    assign col_nxt = (col_r == scbc_pkg::COL_LAST) ? scbc_pkg::COL_ZERO
                                                   : col_r + 1'b1; // [R16]

    // burst sequencer: one column per clock while busy and not suspended
    always_ff @(posedge clock) begin
        if (srst) begin
            burst_busy_r <= 1'b0;
            col_r <= '0;
            left_r <= '0;
            burst_bank_r <= '0;
            burst_ap_r <= 1'b0;
        end else if (is_read(cmd) && bank_active_r[bank_select]) begin
            burst_busy_r <= 1'b1; // [R18]
            col_r <= addr[COL_BITS-1:0]; // [R13]
            left_r <= full_page ? scbc_pkg::FULL_PAGE_LEN : {6'h00, burst_len};
            burst_bank_r <= bank_select;
            burst_ap_r <= (cmd == scbc_pkg::SCBC_READ_AP);
        end else if (cmd == scbc_pkg::SCBC_BURST_STOP || cmd == scbc_pkg::SCBC_CLOSE_ALL
                     || (cmd == scbc_pkg::SCBC_CLOSE_ONE && bank_select == burst_bank_r)) begin
            burst_busy_r <= 1'b0; // [R19]
        end else if (burst_busy_r && power_state_r != scbc_pkg::SCBC_SUSPEND) begin
            col_r <= col_nxt; // [R14]
            if (!full_page) begin
                left_r <= left_r - 10'h001;
                if (stop_hit) burst_busy_r <= 1'b0;
            end
        end
    end

    // a fetch for the current column enters the cas pipeline each busy cycle outside suspend with no close or burst stop
    always_ff @(posedge clock) begin
        if (srst) begin
            array_bank_r <= '0;
            array_row_r <= '0;
            array_col_r <= '0;
            valid_pipe_r <= '0;
        end else begin
            array_bank_r <= burst_bank_r;
            array_row_r <= open_row;
            array_col_r <= col_r;
            // the fetch on a new read's edge still belongs to the old burst [R18]
            valid_pipe_r <= {valid_pipe_r[CAS_LAT-2:0],
                             burst_busy_r && power_state_r != scbc_pkg::SCBC_SUSPEND}; // [R14]
            if (is_close(cmd) || cmd == scbc_pkg::SCBC_BURST_STOP) valid_pipe_r <= '0;
        end
    end

    // array words wait here so each meets its enable from the cas pipeline
    always_ff @(posedge clock) begin
        word_pipe_r[0] <= array_data;
        for (int i = 1; i < CAS_LAT - 1; i++) begin
            word_pipe_r[i] <= word_pipe_r[i-1];
        end
    end

    // mask pipeline: two clocks of latency on the output enable
    always_ff @(posedge clock) begin
        if (srst) begin
            mask_d1_r <= '1;
            mask_d2_r <= '1;
        end else begin
            mask_d1_r <= byte_mask; // [R17] [R1]
            mask_d2_r <= mask_d1_r;
        end
    end

    generate
        for (genvar g = 0; g < scbc_pkg::MASK_W; g++) begin : g_lane
            always_ff @(posedge clock) begin
                if (srst) begin
                    dq_out_r[g*LANE_W +: LANE_W] <= '0;
                    dq_oe_r[g*LANE_W +: LANE_W] <= '0;
                end else begin
                    dq_out_r[g*LANE_W +: LANE_W] <= word_pipe_r[CAS_LAT-2][g*LANE_W +: LANE_W];
                    // released when no word is due [R15], masked lane off [R26] [R17]
                    dq_oe_r[g*LANE_W +: LANE_W] <=
                        {LANE_W{valid_pipe_r[CAS_LAT-1] && !mask_d2_r[g]}};
                end
            end
        end
    endgenerate

    // power state: a power-down request during a burst becomes suspend
    always_ff @(posedge clock) begin
        if (srst) begin
            power_state_r <= scbc_pkg::SCBC_RUN;
            refresh_pulse_r <= 1'b0;
        end else begin
            refresh_pulse_r <= (cmd == scbc_pkg::SCBC_AUTO_REFRESH); // [R25]
            case (power_state_r)
                scbc_pkg::SCBC_RUN: begin
                    if (cmd == scbc_pkg::SCBC_SELF_REFRESH) begin
                        power_state_r <= scbc_pkg::SCBC_SELF_REF; // [R25]
                    end else if (cke_prev_r && !cke) begin
                        power_state_r <= burst_busy_r ? scbc_pkg::SCBC_SUSPEND
                                                      : scbc_pkg::SCBC_POWER_DOWN; // [R23]
                    end
                end
                scbc_pkg::SCBC_SUSPEND, scbc_pkg::SCBC_POWER_DOWN,
                scbc_pkg::SCBC_SELF_REF: begin
                    if (cke) power_state_r <= scbc_pkg::SCBC_RUN;
                end
                default: power_state_r <= scbc_pkg::SCBC_RUN;
            endcase
        end
    end

    // checks
    open_bank_a: assert property (@(posedge clock) disable iff (srst)
        cmd == scbc_pkg::SCBC_ROW_OPEN |=> bank_active_r[$past(bank_select)]) // [R4]
        else $error("row open did not activate bank");
    close_all_a: assert property (@(posedge clock) disable iff (srst)
        cmd == scbc_pkg::SCBC_CLOSE_ALL |=> bank_active_r == '0) // [R10]
        else $error("close all left a bank open");
    close_one_a: assert property (@(posedge clock) disable iff (srst)
        cmd == scbc_pkg::SCBC_CLOSE_ONE |=> !bank_active_r[$past(bank_select)]) // [R9]
        else $error("single close left bank open");
    deselect_a: assert property (@(posedge clock) disable iff (srst)
        cs_n && cke_prev_r |-> cmd == scbc_pkg::SCBC_DESELECT) // [R24]
        else $error("deselected command decoded");
    cke_gate_a: assert property (@(posedge clock) disable iff (srst)
        !cke_prev_r |-> cmd == scbc_pkg::SCBC_INHIBIT) // [R2]
        else $error("command taken with low earlier clock enable");
    mask_lat_a: assert property (@(posedge clock) disable iff (srst)
        byte_mask[0] |-> ##3 !dq_oe_r[0]) // [R17]
        else $error("masked lane driven");
    read_stop_a: assert property (@(posedge clock) disable iff (srst)
        cmd == scbc_pkg::SCBC_CLOSE_ALL |=> !burst_busy_r ##1 valid_pipe_r == '0) // [R19]
        else $error("precharge did not end burst");
    page_wrap_a: assert property (@(posedge clock) disable iff (srst)
        burst_busy_r && full_page && col_r == scbc_pkg::COL_LAST && !is_read(cmd)
        && cmd == scbc_pkg::SCBC_NOP && power_state_r == scbc_pkg::SCBC_RUN
        |=> col_r == scbc_pkg::COL_ZERO) // [R16]
        else $error("full page did not wrap");
    suspend_a: assert property (@(posedge clock) disable iff (srst)
        power_state_r == scbc_pkg::SCBC_RUN && burst_busy_r && cke_prev_r && !cke
        && cmd != scbc_pkg::SCBC_SELF_REFRESH |=> power_state_r == scbc_pkg::SCBC_SUSPEND) // [R23]
        else $error("power down entered during burst");
    cut_one_a: assert property (@(posedge clock) disable iff (srst)
        burst_busy_r && cmd == scbc_pkg::SCBC_CLOSE_ONE && bank_select == burst_bank_r
        |=> !burst_busy_r && valid_pipe_r == '0) // [R19]
        else $error("bank close did not cut its burst");
    stop_cmd_a: assert property (@(posedge clock) disable iff (srst)
        cmd == scbc_pkg::SCBC_BURST_STOP |=> !burst_busy_r) // [R25]
        else $error("burst stop left burst running");
    release_a: assert property (@(posedge clock) disable iff (srst)
        !valid_pipe_r[CAS_LAT-1] |=> dq_oe_r == '0) // [R15]
        else $error("data driven with no word due");
    mask_hi_a: assert property (@(posedge clock) disable iff (srst)
        byte_mask[1] |-> ##3 !dq_oe_r[scbc_pkg::DQ_W-1]) // [R17] [R26]
        else $error("masked upper lane driven");
    lane_on_a: assert property (@(posedge clock) disable iff (srst)
        valid_pipe_r[CAS_LAT-1] && !mask_d2_r[0] |=> dq_oe_r[0]) // [R26]
        else $error("unmasked lane not driven");
    refresh_a: assert property (@(posedge clock) disable iff (srst)
        cmd == scbc_pkg::SCBC_AUTO_REFRESH |=> refresh_pulse_r) // [R25]
        else $error("auto refresh not signalled");
    idle_read_a: assert property (@(posedge clock) disable iff (srst)
        is_read(cmd) && !bank_active_r[bank_select] && !burst_busy_r |=> !burst_busy_r) // [R13]
        else $error("read to idle bank started a burst");
    read_cover_c: cover property (@(posedge clock) disable iff (srst)
        cmd == scbc_pkg::SCBC_READ ##[1:4] dq_oe_r != '0);
    interrupt_cover_c: cover property (@(posedge clock) disable iff (srst)
        burst_busy_r && cmd == scbc_pkg::SCBC_READ);
    suspend_cover_c: cover property (@(posedge clock) disable iff (srst)
        power_state_r == scbc_pkg::SCBC_SUSPEND);
    wrap_cover_c: cover property (@(posedge clock) disable iff (srst)
        burst_busy_r && full_page && col_r == scbc_pkg::COL_LAST);
endmodule : scbc_ctrl

// >>> dv/scbc_host_model.sv
// command-side model of the memory controller that drives the block
`timescale 1ns/10ps
module scbc_host_model #(
    parameter int GAP = 3
) (
    // clock
    input wire logic clock,
    // command pins
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [scbc_pkg::BANK_W-1:0] bank_select,
    output logic [scbc_pkg::ROW_W-1:0] addr,
    output logic [scbc_pkg::MASK_W-1:0] byte_mask
);
    // pins move only at the falling edge, so they are settled for the rising one
    task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
        {cs_n, ras_n, cas_n, we_n} = c;
        bank_select = b;
        addr = a;
        @(negedge clock);
    endtask : cmd
    task automatic nop();
        {cs_n, ras_n, cas_n, we_n} = 4'h7;
    endtask : nop
    task automatic pins(input logic k, input logic [1:0] m);
        cke = k;
        byte_mask = m;
    endtask : pins
    // idle padding after each open covers every open-related delay; banks are opened
    // only while idle, closed long before any active limit, and reads never meet writes
    task automatic act(input logic [1:0] b, input logic [12:0] r);
        cmd(4'h3, b, r);
        nop();
        repeat (GAP) @(negedge clock);
    endtask : act
    initial begin
        pins(1'b1, 2'h0);
        nop();
        bank_select = 2'h0;
        addr = 13'h0000;
    end
endmodule : scbc_host_model

// >>> dv/scbc_ctrl_tb.sv
// self-checking bench for the sdram command and bank control block
`timescale 1ns/10ps
module scbc_ctrl_tb;
    localparam int CAS = 2;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic cke, cs_n, ras_n, cas_n, we_n;
    logic [1:0] bank_select, byte_mask, array_bank_r;
    logic [12:0] addr, array_row_r;
    logic [8:0] array_col_r;
    logic [3:0] burst_len = 4'h4;
    logic full_page = 1'b0;
    logic [15:0] array_data, dq_out_r, dq_oe_r;
    logic [3:0] bank_active_r;
    scbc_pkg::scbc_pwr_t power_state_r;
    logic refresh_pulse_r, burst_busy_r;
    logic [15:0] seed = 16'h0011;
    logic [12:0] rows [4];
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;

    scbc_host_model #(.GAP(3)) i_scbc_host_model (.clock(clock), .cke(cke), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_select(bank_select), .addr(addr),
        .byte_mask(byte_mask));
    scbc_ctrl #(.CAS_LAT(CAS)) i_scbc_ctrl (.clock(clock), .srst(srst), .cke(cke),
        .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_select(bank_select),
        .addr(addr), .byte_mask(byte_mask), .burst_len(burst_len), .full_page(full_page),
        .array_data(array_data), .array_bank_r(array_bank_r), .array_row_r(array_row_r),
        .array_col_r(array_col_r), .dq_out_r(dq_out_r), .dq_oe_r(dq_oe_r),
        .bank_active_r(bank_active_r), .power_state_r(power_state_r),
        .refresh_pulse_r(refresh_pulse_r), .burst_busy_r(burst_busy_r));

    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction : rnd
    // every array word carries its bank, low row bits and column, so misrouting shows
    function automatic logic [15:0] word(input logic [1:0] b, input logic [12:0] r,
        input logic [8:0] c);
        return {b, r[4:0], c};
    endfunction : word
    assign array_data = word(array_bank_r, array_row_r, array_col_r);

    initial begin
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(negedge clock);
    endtask : step
    task automatic go(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
        i_scbc_host_model.cmd(c, b, a);
        i_scbc_host_model.nop();
    endtask : go
    task automatic done(input string s);
        $display("test %s done", s);
    endtask : done
    task automatic do_reset();
        srst = 1'b1;
        step(3);
        srst = 1'b0;
        check(16'(bank_active_r), 16'h0000, "idle");
        check(dq_oe_r, 16'h0000, "oe");
        check(16'(power_state_r), 16'(scbc_pkg::SCBC_RUN), "run");
    endtask : do_reset
    task automatic burst_chk(input int w, input logic [1:0] b, input logic [8:0] c, input int n);
        step(w);
        for (int i = 0; i < n; i++) begin
            check(dq_oe_r, 16'hffff, "enable");
            check(dq_out_r, word(b, rows[b], c + 9'(i)), "data");
            step(1);
        end
        if (!full_page) check(dq_oe_r, 16'h0000, "release");
    endtask : burst_chk
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        logic [1:0] b;
        logic [8:0] c;
        logic [15:0] r;
        @(negedge clock);
        do_reset();
        for (int i = 0; i < 4; i++) begin
            rows[i] = 13'(rnd());
            i_scbc_host_model.act(2'(i), rows[i]);
        end
        check(16'(bank_active_r), 16'h000f, "open");
        for (int k = 0; k < 4; k++) begin
            burst_len = 4'(1 << k);
            b = 2'(rnd());
            c = 9'(rnd()) & 9'h1f8;
            go(4'h5, b, 13'(c));
            burst_chk(CAS + 1, b, c, 1 << k);
        end
        done("bursts");
        burst_len = 4'h4;
        i_scbc_host_model.cmd(4'h5, 2'h0, 13'h0000);
        go(4'h5, 2'h1, 13'h0010);
        step(2);
        check(dq_out_r, word(2'h0, rows[0], 9'h000), "first");
        check(dq_oe_r, 16'hffff, "first oe");
        burst_chk(1, 2'h1, 9'h010, 4);
        burst_len = 4'h8;
        r = rnd();
        go(4'h5, 2'h2, 13'h0020);
        step(3);
        // a one-cycle mask pulse must hit exactly one word, two edges later
        i_scbc_host_model.pins(1'b1, {r[0], ~r[0]});
        step(1);
        i_scbc_host_model.pins(1'b1, 2'h0);
        step(2);
        check(dq_oe_r, r[0] ? 16'h00ff : 16'hff00, "mask");
        step(1);
        check(dq_oe_r, 16'hffff, "unmask");
        step(5);
        i_scbc_host_model.cmd(4'h5, 2'h3, 13'h0040);
        go(4'h2, 2'h3, 13'h0000);
        step(3);
        check(dq_oe_r, 16'h0000, "cut");
        check(16'(bank_active_r), 16'h0007, "close one");
        done("interrupts");
        full_page = 1'b1;
        go(4'h5, 2'h1, 13'h01fe);
        burst_chk(CAS + 1, 2'h1, 9'h1fe, 4);
        go(4'h6, 2'h0, 13'h0000);
        step(5);
        check(dq_oe_r, 16'h0000, "stop");
        full_page = 1'b0;
        go(4'h5, 2'h0, 13'h0000);
        step(1);
        i_scbc_host_model.pins(1'b0, 2'h0);
        step(2);
        check(16'(power_state_r), 16'(scbc_pkg::SCBC_SUSPEND), "suspend");
        i_scbc_host_model.pins(1'b1, 2'h0);
        step(14);
        go(4'h2, 2'(rnd()), 13'h0400);
        check(16'(bank_active_r), 16'h0000, "close all");
        step(1);
        go(4'hb, 2'h0, 13'h0abc);
        check(16'(bank_active_r), 16'h0000, "deselect");
        i_scbc_host_model.pins(1'b0, 2'h0);
        step(2);
        check(16'(power_state_r), 16'(scbc_pkg::SCBC_POWER_DOWN), "down");
        i_scbc_host_model.pins(1'b1, 2'h0);
        go(4'h3, 2'h0, 13'h0000);
        check(16'(bank_active_r), 16'h0000, "cke late");
        step(2);
        go(4'h1, 2'h0, 13'h0000);
        check(16'(refresh_pulse_r), 16'h0001, "refresh");
        step(1);
        check(16'(refresh_pulse_r), 16'h0000, "refresh end");
        i_scbc_host_model.pins(1'b0, 2'h0);
        go(4'h1, 2'h0, 13'h0000);
        step(1);
        check(16'(power_state_r), 16'(scbc_pkg::SCBC_SELF_REF), "self");
        i_scbc_host_model.pins(1'b1, 2'h0);
        do_reset();
        done("power");
        tally_and_finish();
    end
endmodule : scbc_ctrl_tb
